/* cafb_core.sv */
// Acceptance filter, receive buffer flags and transmit buffer control.
//
// The register addresses and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
module cafb_core
  import cafb_pkg::*;
#(
  parameter int NUM_FILTERS = 16,
  parameter int NUM_TX = 8
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rx_valid,
  input wire cafb_frame_t rx_frame,
  output cafb_accept_t rx_accept,
  input wire cafb_tx_evt_t tx_evt,
  output logic tx_pending,
  output logic [2:0] tx_select,
  output logic [NUM_TX-1:0] tx_abort
);

  // ==========================================================
  // Bus slave
  // ==========================================================
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [7:0] rd_addr;
  logic [31:0] rd_word;
  logic [31:0] next_rdata;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend <= hsel && htrans[1] && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready && hsel && htrans[1] && !hwrite)
        hrdata <= next_rdata;
    end
  end

  assign rd_addr = haddr[7:0];
  logic we;
  logic [15:0] wd;
  assign we = wr_pend;
  assign wd = hwdata[15:0];

  // ==========================================================
  // Configuration registers
  // ==========================================================
  logic [15:0] mask_sel_low;
  logic [15:0] mask_sel_high;
  logic [15:0] filter_enable;
  logic [15:0] buf_ptr [4];
  logic [15:0] mask_sid [3];
  logic [15:0] mask_eid [3];
  logic [15:0] filt_sid [NUM_FILTERS];
  logic [15:0] filt_eid [NUM_FILTERS];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mask_sel_low <= RST_ZERO16;
      mask_sel_high <= RST_ZERO16;
      filter_enable <= RST_FILTER_ENABLE;
      for (int i = 0; i < 4; i++)
        buf_ptr[i] <= RST_ZERO16;
      for (int i = 0; i < 3; i++)
      begin
        mask_sid[i] <= RST_ZERO16;
        mask_eid[i] <= RST_ZERO16;
      end
      for (int i = 0; i < NUM_FILTERS; i++)
      begin
        filt_sid[i] <= RST_ZERO16;
        filt_eid[i] <= RST_ZERO16;
      end
    end
    else if (we)
    begin
      if (wr_addr == OFS_MASK_SEL_LOW)
        mask_sel_low <= wd;
      if (wr_addr == OFS_MASK_SEL_HIGH)
        mask_sel_high <= wd;
      if (wr_addr == OFS_FILTER_ENABLE)
        filter_enable <= wd;
      for (int i = 0; i < 4; i++)
        if (wr_addr == OFS_BUF_PTR_BASE + 8'(4 * i))
          buf_ptr[i] <= wd;
      for (int i = 0; i < 3; i++)
      begin
        // Unimplemented bits 4 and 2 are held at zero.
        if (wr_addr == OFS_MASK_SID_BASE + 8'(4 * i))
          mask_sid[i] <= wd & 16'hFFEB;
        if (wr_addr == OFS_MASK_EID_BASE + 8'(4 * i))
          mask_eid[i] <= wd;
      end
      for (int i = 0; i < NUM_FILTERS; i++)
      begin
        if (wr_addr == OFS_FILT_SID_BASE + 8'(4 * i))
          filt_sid[i] <= wd & 16'hFFEB;
        if (wr_addr == OFS_FILT_EID_BASE + 8'(4 * i))
          filt_eid[i] <= wd;
      end
    end
  end

  // ==========================================================
  // Acceptance filtering
  // ==========================================================
  logic [31:0] sel_all;
  logic [NUM_FILTERS-1:0] match;
  assign sel_all = {mask_sel_high, mask_sel_low};

  genvar g;
  generate
    for (g = 0; g < NUM_FILTERS; g++)
    begin : g_filt
      logic [1:0] src;
      logic [15:0] msid;
      logic [15:0] meid;
      logic [28:0] want;
      logic [28:0] got;
      logic [28:0] care;
      logic type_ok;
      assign src = sel_all[2*g +: 2];
      assign msid = (src == MSK_NONE) ? 16'h0000 : mask_sid[src];
      assign meid = (src == MSK_NONE) ? 16'h0000 : mask_eid[src];
      assign care = {msid[15:SID_LSB], msid[1:0], meid};
      assign want = {filt_sid[g][15:SID_LSB], filt_sid[g][1:0], filt_eid[g]};
      assign got = {rx_frame.sid, rx_frame.eid};
      assign type_ok = !msid[FRAME_TYPE_BIT] ||
        (filt_sid[g][FRAME_TYPE_BIT] == rx_frame.extended);
      assign match[g] = filter_enable[g] && type_ok &&
        (((want ^ got) & care) == 29'h00000000);
    end
  endgenerate

  logic hit_any;
  logic [4:0] hit_num;
  logic [3:0] hit_ptr;
  always_comb
  begin
    hit_any = 1'b0;
    hit_num = 5'h00;
    for (int i = NUM_FILTERS - 1; i >= 0; i--)
      if (match[i])
      begin
        hit_any = 1'b1;
        hit_num = 5'(i);
      end
    hit_ptr = buf_ptr[hit_num[3:2]][4*hit_num[1:0] +: 4];
  end

  // ==========================================================
  // Buffer control bytes
  // ==========================================================
  logic [7:0] ctrl [NUM_TX];
  logic rx_store;
  logic remote_hit;
  logic [31:0] rx_full;
  logic [31:0] rx_ovf;

  assign rx_store = rx_valid && hit_any && !rx_frame.remote;
  assign remote_hit = rx_valid && hit_any && rx_frame.remote &&
    (hit_ptr < 4'(NUM_TX));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < NUM_TX; i++)
        ctrl[i] <= RST_CTRL;
      tx_abort <= '0;
    end
    else
    begin
      tx_abort <= '0;
      for (int i = 0; i < NUM_TX; i++)
      begin
        logic [7:0] c;
        logic req_set;
        c = ctrl[i];
        req_set = 1'b0;
        if (we && wr_addr == OFS_BUF_CTRL_BASE + 8'(4 * (i / 2)))
        begin
          logic [7:0] b;
          b = wd[8*(i%2) +: 8];
          c[CTL_DIR] = b[CTL_DIR];
          c[CTL_RTR] = b[CTL_RTR];
          c[1:0] = b[1:0];
          if (ctrl[i][CTL_REQ] && !b[CTL_REQ])
          begin
            tx_abort[i] <= 1'b1;
            c[CTL_ABT] = 1'b1;
          end
          req_set = b[CTL_REQ] && !ctrl[i][CTL_REQ];
          c[CTL_REQ] = b[CTL_REQ];
        end
        if (remote_hit && hit_ptr[2:0] == 3'(i) &&
            c[CTL_RTR] && c[CTL_DIR] && !c[CTL_REQ])
        begin
          c[CTL_REQ] = 1'b1;
          req_set = 1'b1;
        end
        if (tx_evt.buf_idx == 3'(i) && ctrl[i][CTL_REQ])
        begin
          if (tx_evt.lost_arb)
            c[CTL_LARB] = 1'b1;
          if (tx_evt.bus_error)
            c[CTL_ERR] = 1'b1;
          if (tx_evt.done_ok)
            c[CTL_REQ] = 1'b0;
        end
        if (req_set)
          c[6:4] = 3'h0;
        ctrl[i] <= c;
      end
    end
  end

  // ==========================================================
  // Receive full and overflow flags
  // ==========================================================
  // Contents held externally
  logic [4:0] store_idx;
  logic store_buf;
  assign store_idx = {1'b0, hit_ptr};
  assign store_buf = rx_store && hit_ptr != PTR_FIFO &&
    !(hit_ptr < 4'(NUM_TX) && ctrl[hit_ptr[2:0]][CTL_DIR]);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_full <= '0;
      rx_ovf <= '0;
    end
    else
    begin
      for (int i = 0; i < 32; i++)
      begin
        logic f;
        logic o;
        f = rx_full[i];
        o = rx_ovf[i];
        if (we && wr_addr == (i < 16 ? OFS_RX_FULL_LOW : OFS_RX_FULL_HIGH)
            && !wd[i % 16])
          f = 1'b0;
        if (we && wr_addr == (i < 16 ? OFS_RX_OVF_LOW : OFS_RX_OVF_HIGH)
            && !wd[i % 16])
          o = 1'b0;
        if (store_buf && store_idx == 5'(i))
        begin
          if (rx_full[i])
            o = 1'b1;
          f = 1'b1;
        end
        rx_full[i] <= f;
        rx_ovf[i] <= o;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rx_accept <= '0;
    else
    begin
      rx_accept.valid <= rx_store &&
        (hit_ptr == PTR_FIFO || store_buf);
      rx_accept.to_fifo <= hit_ptr == PTR_FIFO;
      rx_accept.buf_idx <= hit_ptr;
      rx_accept.hit <= hit_num;
    end
  end

  // ==========================================================
  // Transmit selection
  // ==========================================================
  logic sel_any;
  logic [2:0] sel_idx;
  logic [1:0] sel_pri;
  always_comb
  begin
    sel_any = 1'b0;
    sel_idx = 3'h0;
    sel_pri = 2'h0;
    for (int i = 0; i < NUM_TX; i++)
      if (ctrl[i][CTL_DIR] && ctrl[i][CTL_REQ] &&
          (!sel_any || ctrl[i][1:0] > sel_pri))
      begin
        sel_any = 1'b1;
        sel_idx = 3'(i);
        sel_pri = ctrl[i][1:0];
      end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_pending <= 1'b0;
      tx_select <= 3'h0;
    end
    else
    begin
      tx_pending <= sel_any;
      tx_select <= sel_idx;
    end
  end

  // ==========================================================
  // Read mux
  // ==========================================================
  always_comb
  begin
    rd_word = 32'h00000000;
    if (rd_addr == OFS_MASK_SEL_LOW)
      rd_word[15:0] = mask_sel_low;
    if (rd_addr == OFS_MASK_SEL_HIGH)
      rd_word[15:0] = mask_sel_high;
    if (rd_addr == OFS_FILTER_ENABLE)
      rd_word[15:0] = filter_enable;
    for (int i = 0; i < 4; i++)
      if (rd_addr == OFS_BUF_PTR_BASE + 8'(4 * i))
        rd_word[15:0] = buf_ptr[i];
    for (int i = 0; i < 3; i++)
    begin
      if (rd_addr == OFS_MASK_SID_BASE + 8'(4 * i))
        rd_word[15:0] = mask_sid[i];
      if (rd_addr == OFS_MASK_EID_BASE + 8'(4 * i))
        rd_word[15:0] = mask_eid[i];
    end
    for (int i = 0; i < NUM_FILTERS; i++)
    begin
      if (rd_addr == OFS_FILT_SID_BASE + 8'(4 * i))
        rd_word[15:0] = filt_sid[i];
      if (rd_addr == OFS_FILT_EID_BASE + 8'(4 * i))
        rd_word[15:0] = filt_eid[i];
    end
    if (rd_addr == OFS_RX_FULL_LOW)
      rd_word[15:0] = rx_full[15:0];
    if (rd_addr == OFS_RX_FULL_HIGH)
      rd_word[15:0] = rx_full[31:16];
    if (rd_addr == OFS_RX_OVF_LOW)
      rd_word[15:0] = rx_ovf[15:0];
    if (rd_addr == OFS_RX_OVF_HIGH)
      rd_word[15:0] = rx_ovf[31:16];
    for (int i = 0; i < NUM_TX / 2; i++)
      if (rd_addr == OFS_BUF_CTRL_BASE + 8'(4 * i))
        rd_word[15:0] = {ctrl[2*i+1], ctrl[2*i]};
    if (rd_addr == OFS_TX_STATUS)
      rd_word[3:0] = {tx_select, tx_pending};
    next_rdata = rd_word;
  end

endmodule // cafb_core

/* cafb_pkg.sv */
// Package with register map, field layouts and shared types.
package cafb_pkg;

  // ==========================================================
  // Register byte offsets
  // ==========================================================
  localparam logic [7:0] OFS_MASK_SEL_LOW = 8'h00;
  localparam logic [7:0] OFS_MASK_SEL_HIGH = 8'h04;
  localparam logic [7:0] OFS_FILTER_ENABLE = 8'h08;
  localparam logic [7:0] OFS_BUF_PTR_BASE = 8'h10;
  localparam logic [7:0] OFS_MASK_SID_BASE = 8'h20;
  localparam logic [7:0] OFS_MASK_EID_BASE = 8'h30;
  localparam logic [7:0] OFS_FILT_SID_BASE = 8'h40;
  localparam logic [7:0] OFS_FILT_EID_BASE = 8'h80;
  localparam logic [7:0] OFS_RX_FULL_LOW = 8'hC0;
  localparam logic [7:0] OFS_RX_FULL_HIGH = 8'hC4;
  localparam logic [7:0] OFS_RX_OVF_LOW = 8'hC8;
  localparam logic [7:0] OFS_RX_OVF_HIGH = 8'hCC;
  localparam logic [7:0] OFS_BUF_CTRL_BASE = 8'hD0;
  localparam logic [7:0] OFS_TX_STATUS = 8'hE0;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int SID_LSB = 5;
  localparam int FRAME_TYPE_BIT = 3;
  localparam int CTL_DIR = 7;
  localparam int CTL_ABT = 6;
  localparam int CTL_LARB = 5;
  localparam int CTL_ERR = 4;
  localparam int CTL_REQ = 3;
  localparam int CTL_RTR = 2;
  localparam logic [1:0] MSK_NONE = 2'h3;
  localparam logic [3:0] PTR_FIFO = 4'hF;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [15:0] RST_FILTER_ENABLE = 16'hFFFF;
  localparam logic [15:0] RST_ZERO16 = 16'h0000;
  localparam logic [7:0] RST_CTRL = 8'h00;

  // Received frame header as presented by the protocol engine.
  typedef struct packed {
    logic extended;
    logic remote;
    logic [10:0] sid;
    logic [17:0] eid;
  } cafb_frame_t;

  // Transmit outcome event from the protocol engine.
  typedef struct packed {
    logic done_ok;
    logic lost_arb;
    logic bus_error;
    logic [2:0] buf_idx;
  } cafb_tx_evt_t;

  // Accepted-message result toward the message storage logic.
  typedef struct packed {
    logic valid;
    logic to_fifo;
    logic [3:0] buf_idx;
    logic [4:0] hit;
  } cafb_accept_t;

endpackage : cafb_pkg

/* cafb_core_props.sv */
// Port checker for the filter and buffer control block.
`timescale 1ns/1ps
module cafb_core_props
  import cafb_pkg::*;
#(
  parameter int NUM_FILTERS = 16,
  parameter int NUM_TX = 8
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic rx_valid,
  input wire cafb_accept_t rx_accept,
  input wire logic [NUM_TX-1:0] tx_abort
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========
  // Bus answers
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  ready_high_a: assert property ($past(hresetn) |-> hreadyout)
    else $error("ready low after reset");
  upper_zero_a: assert property (hrdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  // ==========
  // Acceptance and abort
  accept_cause_a: assert property (rx_accept.valid |-> $past(rx_valid))
    else $error("accept without frame");
  accept_ptr_a: assert property (
    rx_accept.valid && !rx_accept.to_fifo |-> rx_accept.buf_idx != PTR_FIFO)
    else $error("buffer index is fifo code");
  hit_range_a: assert property (
    rx_accept.valid |-> rx_accept.hit < NUM_FILTERS)
    else $error("hit number out of range");
  abort_pulse_a: assert property ((tx_abort & $past(tx_abort)) == '0)
    else $error("abort longer than one cycle");
  abort_cause_a: assert property (
    tx_abort != '0 |-> $past(hsel && htrans[1] && hwrite, 2))
    else $error("abort without write");
endmodule // cafb_core_props

bind cafb_core cafb_core_props #(
  .NUM_FILTERS(NUM_FILTERS),
  .NUM_TX(NUM_TX)
) cafb_core_props_inst (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .htrans(htrans),
  .hwrite(hwrite),
  .hrdata(hrdata),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .rx_valid(rx_valid),
  .rx_accept(rx_accept),
  .tx_abort(tx_abort)
);

/* cafb_engine_model.sv */
// Far-side protocol engine model: incoming frames and send outcomes.
`timescale 1ns/1ps
module cafb_engine_model
  import cafb_pkg::*;
(
  input wire logic hclk,
  input wire logic [2:0] tx_select,
  output logic rx_valid,
  output cafb_frame_t rx_frame,
  output cafb_tx_evt_t tx_evt
);
  initial
  begin
    rx_valid = 1'b0;
    rx_frame = '0;
    tx_evt = '0;
  end
  // ==========
  // Frame delivery
  task automatic send_frame(input cafb_frame_t f);
    @(posedge hclk);
    rx_valid <= 1'b1;
    rx_frame <= f;
    @(posedge hclk);
    rx_valid <= 1'b0;
    // Idle lines carry the inverse header; rx_valid low keeps it from being accepted.
    rx_frame <= ~f;
  endtask
  // ==========
  // Send outcomes: 0 success, 1 lost arbitration, 2 bus error
  task automatic tx_outcome(input int kind, input int lag);
    repeat (lag) @(posedge hclk);
    tx_evt <= '{kind == 0, kind == 1, kind == 2, tx_select};
    @(posedge hclk);
    tx_evt <= '{1'b0, 1'b0, 1'b0, ~tx_select};
  endtask
endmodule // cafb_engine_model

/* cafb_core_test.sv */
// Self-checking bench for the filter and buffer control block.
`timescale 1ns/1ps
module cafb_core_test
  import cafb_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, rx_valid, tx_pending;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, tx_select;
  logic [7:0] tx_abort;
  logic [7:0] abort_seen = 8'h00;
  cafb_frame_t rx_frame;
  cafb_accept_t rx_accept;
  cafb_tx_evt_t tx_evt;
  int err_count = 0;
  int n_checks = 0;

  always #5 hclk = ~hclk;
  always @(posedge hclk) abort_seen <= abort_seen | tx_abort;

  cafb_core cafb_core_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx_valid(rx_valid),
    .rx_frame(rx_frame), .rx_accept(rx_accept), .tx_evt(tx_evt),
    .tx_pending(tx_pending), .tx_select(tx_select), .tx_abort(tx_abort));
  cafb_engine_model cafb_engine_model_inst (.hclk(hclk),
    .tx_select(tx_select), .rx_valid(rx_valid), .rx_frame(rx_frame),
    .tx_evt(tx_evt));

  // ==========
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1)
    begin
      err_count++;
      summarize();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [15:0] d);
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {16'h0000, d};
    wait_rdy();
    rd = hrdata;
  endtask
  // A gap cycle follows each write; the register is already written when xfer returns.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    xfer(1'b1, a, d);
    @(posedge hclk);
  endtask
  task automatic rdc(input string what, input logic [7:0] a,
    input logic [15:0] exp);
    xfer(1'b0, a, 16'h0000);
    chk(what, rd, {16'h0000, exp});
  endtask
  task automatic frame(input logic ext, rem, input logic [10:0] sid,
    input logic [17:0] eid);
    cafb_engine_model_inst.send_frame('{ext, rem, sid, eid});
    #1;
  endtask
  // Filter 0 points at buffer 3; filter 1 takes everything into the fifo.
  task automatic fcase(input logic [1:0] code, input logic ext,
    input logic [10:0] sid, input logic [17:0] eid, input logic f0);
    wr(OFS_MASK_SEL_LOW, {12'h000, 2'b01, code});
    frame(ext, 1'b0, sid, eid);
    chk("accept", {rx_accept.valid, rx_accept.to_fifo, rx_accept.hit},
      {1'b1, !f0, 4'h0, !f0});
    if (f0)
      chk("buf", rx_accept.buf_idx, 4'h3);
    @(posedge hclk);
  endtask

  // ==========
  // Scenarios
  task automatic test_reset();
    rdc("fen", OFS_FILTER_ENABLE, RST_FILTER_ENABLE);
    rdc("msel", OFS_MASK_SEL_HIGH, RST_ZERO16);
    rdc("full", OFS_RX_FULL_HIGH, RST_ZERO16);
    rdc("ovf", OFS_RX_OVF_LOW, RST_ZERO16);
    rdc("ctl", OFS_BUF_CTRL_BASE, {RST_CTRL, RST_CTRL});
    wr(8'hF0, 16'hFFFF);
    rdc("unmapped", 8'hF0, 16'h0000);
    $display("test_reset done");
  endtask
  task automatic test_filter();
    wr(OFS_FILTER_ENABLE, 16'h0003);
    wr(OFS_BUF_PTR_BASE, 16'h00F3);
    wr(OFS_MASK_SID_BASE, 16'hFFE8);
    wr(OFS_MASK_EID_BASE + 8'h08, 16'hFFFF);
    wr(OFS_FILT_SID_BASE, 16'h2460);
    wr(OFS_FILT_EID_BASE, 16'h00A5);
    fcase(2'h0, 1'b0, 11'h123, 18'h00000, 1'b1);
    fcase(2'h0, 1'b0, 11'h124, 18'h00000, 1'b0);
    fcase(2'h0, 1'b1, 11'h123, 18'h00000, 1'b0);
    fcase(2'h1, 1'b1, 11'h124, 18'h00000, 1'b1);
    fcase(2'h2, 1'b1, 11'h7FF, 18'h000A5, 1'b1);
    fcase(2'h2, 1'b1, 11'h123, 18'h000A4, 1'b0);
    fcase(2'h3, 1'b0, 11'h123, 18'h000A5, 1'b1);
    rdc("full", OFS_RX_FULL_LOW, 16'h0008);
    rdc("ovf", OFS_RX_OVF_LOW, 16'h0008);
    wr(OFS_RX_FULL_LOW, 16'hFFFF);
    rdc("full1", OFS_RX_FULL_LOW, 16'h0008);
    wr(OFS_RX_FULL_LOW, 16'h0000);
    rdc("full0", OFS_RX_FULL_LOW, 16'h0000);
    wr(OFS_FILTER_ENABLE, 16'h0001);
    wr(OFS_MASK_SEL_LOW, 16'h0004);
    frame(1'b0, 1'b0, 11'h124, 18'h00000);
    chk("disabled", rx_accept.valid, 1'b0);
    @(posedge hclk);
    $display("test_filter done");
  endtask
  task automatic test_tx();
    wr(OFS_BUF_CTRL_BASE, 16'h8B89);
    rdc("sel", OFS_TX_STATUS, 16'h0003);
    chk("pend", {tx_select, tx_pending}, 4'h3);
    cafb_engine_model_inst.tx_outcome(1, 3);
    rdc("larb", OFS_BUF_CTRL_BASE, 16'hAB89);
    cafb_engine_model_inst.tx_outcome(2, 0);
    xfer(1'b0, OFS_BUF_CTRL_BASE, 16'h0000);
    chk("err", rd[12], 1'b1);
    cafb_engine_model_inst.tx_outcome(0, 1);
    xfer(1'b0, OFS_BUF_CTRL_BASE, 16'h0000);
    chk("done", rd[11], 1'b0);
    rdc("sel0", OFS_TX_STATUS, 16'h0001);
    wr(OFS_BUF_CTRL_BASE, 16'h8381);
    xfer(1'b0, OFS_BUF_CTRL_BASE, 16'h0000);
    chk("abt", rd[7:0], 8'hC1);
    chk("pulse", abort_seen, 8'h01);
    wr(OFS_BUF_CTRL_BASE, 16'h8989);
    rdc("clr", OFS_BUF_CTRL_BASE, 16'h8989);
    rdc("tie", OFS_TX_STATUS, 16'h0001);
    chk("tie_pend", {tx_select, tx_pending}, 4'h1);
    $display("test_tx done");
  endtask
  task automatic test_rtr();
    wr(OFS_BUF_PTR_BASE, 16'h00F2);
    for (int i = 0; i < 2; i++)
    begin
      wr(OFS_BUF_CTRL_BASE + 8'h04, i ? 16'h0084 : 16'h0080);
      frame(1'b0, 1'b1, 11'h123, 18'h00000);
      @(posedge hclk);
      xfer(1'b0, OFS_BUF_CTRL_BASE + 8'h04, 16'h0000);
      chk("rtr", rd[3], i[0]);
    end
    $display("test_rtr done");
  endtask

  initial
  begin
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    test_reset();
    test_filter();
    test_tx();
    test_rtr();
    summarize();
  end
endmodule // cafb_core_test
